//--- rtl/fcs_sequencer.v
`timescale 1ns/1ps
`default_nettype none
`include "fcs_regs.vh"
module fcs_sequencer #(
	parameter [19:0] PROG_CYC  = `FCS_PROG_TIME_US * `FCS_CLK_MHZ,
	parameter [19:0] ERASE_CYC = `FCS_ERASE_TIME_US * `FCS_CLK_MHZ
) (
	input  wire        clk_in,
	input  wire        rst_in,
	input  wire        flash_program_pin_in,
	input  wire        ew_mode_entry_bit_in,
	input  wire        lock_override_bit_in,
	input  wire        acc_req_in,
	input  wire        acc_we_in,
	input  wire [18:0] acc_addr_in,
	input  wire [15:0] acc_wdata_in,
	output reg  [15:0] acc_rdata_out,
	output reg         acc_ack_out,
	output reg         ew_mode_out,
	output reg         flash_ready_flag_out,
	output reg  [7:0]  operation_result_register_out,
	output reg  [18:0] arr_addr_out,
	output reg  [15:0] arr_wdata_out,
	output reg         arr_we_out,
	output reg         arr_erase_out,
	output reg  [3:0]  arr_erase_blk_out,
	input  wire [15:0] arr_rdata_in,
	input  wire [10:0] lock_bits_in,
	output reg         lock_clr_out,
	output reg         lock_set_out,
	output reg  [3:0]  lock_blk_out
);
	// Sequencer states
	localparam [2:0] S_IDLE  = 3'h0;
	localparam [2:0] S_CONF  = 3'h1;
	localparam [2:0] S_PAGE  = 3'h2;
	localparam [2:0] S_PROG  = 3'h3;
	localparam [2:0] S_ERALL = 3'h4;
	localparam [2:0] S_WAIT  = 3'h5;
	// Read modes
	localparam [1:0] R_ARRAY = 2'h0;
	localparam [1:0] R_STAT  = 2'h1;
	localparam [1:0] R_LOCK  = 2'h2;
	// Pending confirm kinds
	localparam [1:0] P_LOCK  = 2'h0;
	localparam [1:0] P_ERASE = 2'h1;
	localparam [1:0] P_ERALL = 2'h2;

	reg  [2:0]  state_q;
	reg  [1:0]  rmode_q;
	reg  [1:0]  pend_q;
	reg         ready_q;
	reg         err_erase_q;
	reg         err_p1_q;
	reg         err_p2_q;
	reg  [10:0] page_base_q;
	reg  [7:0]  wcnt_q;
	reg  [6:0]  pidx_q;
	reg  [19:0] timer_q;
	reg  [3:0]  eblk_q;
	reg         erall_q;
	reg         rd_pend_q;
	reg         rd_arr_q;
	reg  [15:0] rd_hold_q;
	reg  [15:0] page_mem [0:127];
	wire        pin_sync;
	wire        ew_mode;
	wire [3:0]  dec_blk;
	wire        dec_last;
	wire        take_wr;
	wire        take_rd;
	wire        any_err;
	wire        blk_locked;
	wire [7:0]  result_word;
	wire [15:0] lock_word;

	// Program pin comes from outside the clock domain
	fcs_sync2 u_pin_sync (
		.clk_in (clk_in),
		.rst_in (rst_in),
		.d_in   (flash_program_pin_in),
		.q_out  (pin_sync)
	);

	// Block decode of the bus address
	fcs_blkdec u_blkdec (
		.addr_in  (acc_addr_in),
		.blk_out  (dec_blk),
		.last_out (dec_last)
	);

	// Lock state of one block, honouring the override bit
	function locked_fn;
		input [10:0] bits;
		input [3:0]  blk;
		input        ovr;
		begin
			locked_fn = ~bits[blk] & ~ovr;
		end
	endfunction

	// Mode, strobes and common terms
	assign ew_mode    = pin_sync & ew_mode_entry_bit_in;
	assign take_wr    = acc_req_in & acc_we_in & ew_mode;
	assign take_rd    = acc_req_in & ~acc_we_in;
	assign any_err    = err_erase_q | err_p1_q | err_p2_q;
	assign blk_locked = locked_fn(lock_bits_in, dec_blk,
		lock_override_bit_in);
	assign result_word = {ready_q, 1'b0, err_erase_q, err_p1_q,
		err_p2_q, 3'h0};
	// Lock value at bit 1, mirror at bit 9, rest zero
	assign lock_word = {6'h0, lock_bits_in[dec_blk], 7'h0,
		lock_bits_in[dec_blk], 1'b0};

	// Page buffer fill, no reset needed for data storage
	always @(posedge clk_in) begin
		if (take_wr && state_q == S_PAGE) begin
			page_mem[acc_addr_in[7:1]] <= acc_wdata_in;
		end
	end

	// Read path: array data, result register or lock status
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_pend_q     <= 1'b0;
			rd_arr_q      <= 1'b0;
			rd_hold_q     <= 16'h0000;
			acc_rdata_out <= 16'h0000;
		end else begin
			rd_pend_q <= take_rd;
			if (take_rd) begin
				if (!ew_mode) begin
					rd_arr_q <= 1'b1;
				end else if (!ready_q || rmode_q == R_STAT) begin
					rd_arr_q  <= 1'b0;
					rd_hold_q <= {8'h00, result_word};
				end else if (rmode_q == R_LOCK) begin
					rd_arr_q  <= 1'b0;
					rd_hold_q <= dec_last ? lock_word : 16'h0000;
				end else begin
					rd_arr_q <= 1'b1;
				end
			end
			if (rd_pend_q) begin
				acc_rdata_out <= rd_arr_q ? arr_rdata_in : rd_hold_q;
			end
		end
	end

	// Bus acknowledge two cycles after the strobe for reads, one cycle after for writes
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			acc_ack_out <= 1'b0;
		end else if (take_rd) begin
			acc_ack_out <= 1'b0;
		end else begin
			acc_ack_out <= rd_pend_q | (acc_req_in & acc_we_in);
		end
	end

	// Status outputs
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ew_mode_out                   <= 1'b0;
			flash_ready_flag_out          <= 1'b1;
			operation_result_register_out <= 8'h80;
		end else begin
			ew_mode_out                   <= ew_mode;
			flash_ready_flag_out          <= ready_q;
			operation_result_register_out <= result_word;
		end
	end

	// Command sequencer
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q           <= S_IDLE;
			rmode_q           <= R_ARRAY;
			pend_q            <= P_LOCK;
			ready_q           <= 1'b1;
			err_erase_q       <= 1'b0;
			err_p1_q          <= 1'b0;
			err_p2_q          <= 1'b0;
			page_base_q       <= 11'h000;
			wcnt_q            <= 8'h00;
			pidx_q            <= 7'h00;
			timer_q           <= 20'h00000;
			eblk_q            <= 4'h0;
			erall_q           <= 1'b0;
			arr_addr_out      <= 19'h00000;
			arr_wdata_out     <= 16'h0000;
			arr_we_out        <= 1'b0;
			arr_erase_out     <= 1'b0;
			arr_erase_blk_out <= 4'h0;
			lock_clr_out      <= 1'b0;
			lock_set_out      <= 1'b0;
			lock_blk_out      <= 4'h0;
		end else begin
			arr_we_out    <= 1'b0;
			arr_erase_out <= 1'b0;
			lock_clr_out  <= 1'b0;
			lock_set_out  <= 1'b0;
			if (take_rd && !ready_q) begin
				arr_addr_out <= arr_addr_out;
			end else if (take_rd) begin
				arr_addr_out <= acc_addr_in;
			end
			case (state_q)
			S_IDLE: begin
				if (take_wr) begin
					case (acc_wdata_in)
					`FCS_CMD_READ: begin
						rmode_q <= R_ARRAY;
					end
					`FCS_CMD_STATUS: begin
						rmode_q <= R_STAT;
					end
					`FCS_CMD_LOCKRD: begin
						rmode_q <= R_LOCK;
					end
					`FCS_CMD_CLEAR: begin
						err_erase_q <= 1'b0;
						err_p1_q    <= 1'b0;
						err_p2_q    <= 1'b0;
					end
					`FCS_CMD_PAGE: begin
						if (!any_err) begin
							state_q <= S_PAGE;
							wcnt_q  <= 8'h00;
						end
					end
					`FCS_CMD_LOCK: begin
						state_q <= S_CONF;
						pend_q  <= P_LOCK;
					end
					`FCS_CMD_ERASE: begin
						state_q <= S_CONF;
						pend_q  <= P_ERASE;
					end
					`FCS_CMD_ERALL: begin
						state_q <= S_CONF;
						pend_q  <= P_ERALL;
					end
					default: begin
						rmode_q <= rmode_q;
					end
					endcase
				end
			end
			S_CONF: begin
				if (take_wr) begin
					if (acc_wdata_in == `FCS_CMD_READ) begin
						state_q <= S_IDLE;
						rmode_q <= R_ARRAY;
					end else if (acc_wdata_in != `FCS_CMD_CONFIRM) begin
						state_q <= S_IDLE;
						if (pend_q == P_LOCK) begin
							err_p1_q <= 1'b1;
						end else begin
							err_erase_q <= 1'b1;
						end
					end else if (any_err) begin
						state_q <= S_IDLE;
					end else if (pend_q == P_ERALL) begin
						state_q <= S_ERALL;
						ready_q <= 1'b0;
						erall_q <= 1'b1;
						eblk_q  <= 4'h0;
					end else if (!dec_last) begin
						state_q <= S_IDLE;
						if (pend_q == P_LOCK) begin
							err_p1_q <= 1'b1;
						end else begin
							err_erase_q <= 1'b1;
						end
					end else if (pend_q == P_LOCK) begin
						state_q      <= S_WAIT;
						ready_q      <= 1'b0;
						erall_q      <= 1'b0;
						lock_clr_out <= 1'b1;
						lock_blk_out <= dec_blk;
						timer_q      <= PROG_CYC;
					end else if (blk_locked) begin
						state_q     <= S_IDLE;
						err_erase_q <= 1'b1;
					end else begin
						state_q           <= S_WAIT;
						ready_q           <= 1'b0;
						erall_q           <= 1'b0;
						arr_erase_out     <= 1'b1;
						arr_erase_blk_out <= dec_blk;
						lock_set_out      <= lock_override_bit_in;
						lock_blk_out      <= dec_blk;
						timer_q           <= ERASE_CYC;
					end
				end
			end
			S_PAGE: begin
				if (take_wr) begin
					if (wcnt_q == 8'h00 && blk_locked) begin
						state_q  <= S_IDLE;
						err_p1_q <= 1'b1;
					end else if (wcnt_q != 8'h00 &&
						acc_addr_in[18:8] != page_base_q) begin
						state_q  <= S_IDLE;
						err_p2_q <= 1'b1;
					end else begin
						if (wcnt_q == 8'h00) begin
							page_base_q <= acc_addr_in[18:8];
						end
						wcnt_q <= wcnt_q + 8'h01;
						if (wcnt_q == `FCS_PAGE_WORDS - 8'h01) begin
							state_q <= S_PROG;
							ready_q <= 1'b0;
							pidx_q  <= 7'h00;
						end
					end
				end
			end
			S_PROG: begin
				arr_we_out    <= 1'b1;
				arr_addr_out  <= {page_base_q, pidx_q, 1'b0};
				arr_wdata_out <= page_mem[pidx_q];
				pidx_q        <= pidx_q + 7'h01;
				if (pidx_q == `FCS_LAST_WORD) begin
					state_q <= S_WAIT;
					erall_q <= 1'b0;
					timer_q <= PROG_CYC;
				end
			end
			S_ERALL: begin
				if (!lock_bits_in[eblk_q] && !lock_override_bit_in) begin
					if (eblk_q == `FCS_LAST_BLK) begin
						state_q <= S_IDLE;
						ready_q <= 1'b1;
						erall_q <= 1'b0;
					end
					eblk_q <= eblk_q + 4'h1;
				end else begin
					state_q           <= S_WAIT;
					arr_erase_out     <= 1'b1;
					arr_erase_blk_out <= eblk_q;
					lock_set_out      <= lock_override_bit_in;
					lock_blk_out      <= eblk_q;
					timer_q           <= ERASE_CYC;
				end
			end
			S_WAIT: begin
				if (timer_q > 20'h00001) begin
					timer_q <= timer_q - 20'h00001;
				end else if (erall_q && eblk_q != `FCS_LAST_BLK) begin
					state_q <= S_ERALL;
					eblk_q  <= eblk_q + 4'h1;
				end else begin
					state_q <= S_IDLE;
					ready_q <= 1'b1;
					erall_q <= 1'b0;
				end
				if (take_wr && acc_wdata_in == `FCS_CMD_STATUS) begin
					rmode_q <= R_STAT;
				end
			end
			default: begin
				state_q <= S_IDLE;
			end
			endcase
		end
	end
endmodule
`default_nettype wire

//--- include/fcs_regs.vh
`ifndef FCS_REGS_VH
`define FCS_REGS_VH
// Command codes
`define FCS_CMD_READ      16'hffff
`define FCS_CMD_PAGE      16'h4141
`define FCS_CMD_LOCK      16'h7777
`define FCS_CMD_ERASE     16'h2020
`define FCS_CMD_ERALL     16'ha7a7
`define FCS_CMD_STATUS    16'h7070
`define FCS_CMD_CLEAR     16'h5050
`define FCS_CMD_LOCKRD    16'h7171
`define FCS_CMD_CONFIRM   16'hd0d0
// Geometry
`define FCS_AW            19
`define FCS_NBLK          11
`define FCS_LAST_BLK      4'ha
`define FCS_PAGE_WORDS    8'h80
`define FCS_LAST_WORD     7'h7f
// Block ends
`define FCS_END_B0        19'h03ffe
`define FCS_END_B1        19'h05ffe
`define FCS_END_B2        19'h07ffe
`define FCS_END_B3        19'h0fffe
`define FCS_LARGE_END     16'hfffe
`define FCS_LARGE_BASE    4'h3
// Result register bits
`define FCS_RES_READY     7
`define FCS_RES_ERASE     5
`define FCS_RES_PERR1     4
`define FCS_RES_PERR2     3
// Lock status word bits
`define FCS_LW_LOCK0      1
`define FCS_LW_LOCK1      9
// Timing
`define FCS_CLK_MHZ       20
`define FCS_PROG_TIME_US  8000
`define FCS_ERASE_TIME_US 50000
`endif

//--- rtl/fcs_sync2.v
`timescale 1ns/1ps
`default_nettype none
module fcs_sync2 (
	input  wire clk_in,
	input  wire rst_in,
	input  wire d_in,
	output reg  q_out
);
	reg meta_q;

	// Two-stage level synchroniser
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_q <= 1'b0;
			q_out  <= 1'b0;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule
`default_nettype wire

//--- rtl/fcs_blkdec.v
`timescale 1ns/1ps
`default_nettype none
`include "fcs_regs.vh"
module fcs_blkdec (
	input  wire [18:0] addr_in,
	output reg  [3:0]  blk_out,
	output reg         last_out
);
	// Block index and last-even-address test
	always @* begin
		if (addr_in <= `FCS_END_B0 + 19'h1) begin
			blk_out  = 4'h0;
			last_out = (addr_in == `FCS_END_B0);
		end else if (addr_in <= `FCS_END_B1 + 19'h1) begin
			blk_out  = 4'h1;
			last_out = (addr_in == `FCS_END_B1);
		end else if (addr_in <= `FCS_END_B2 + 19'h1) begin
			blk_out  = 4'h2;
			last_out = (addr_in == `FCS_END_B2);
		end else if (addr_in <= `FCS_END_B3 + 19'h1) begin
			blk_out  = 4'h3;
			last_out = (addr_in == `FCS_END_B3);
		end else begin
			blk_out  = {1'b0, addr_in[18:16]} + `FCS_LARGE_BASE;
			last_out = (addr_in[15:0] == `FCS_LARGE_END);
		end
	end
endmodule
`default_nettype wire

//--- testbench/fcs_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_chk #(
	parameter [19:0] PROG_CYC  = 20,
	parameter [19:0] ERASE_CYC = 30
) (
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic       flash_program_pin_in,
	input wire logic       ew_mode_entry_bit_in,
	input wire logic       acc_req_in,
	input wire logic       acc_we_in,
	input wire logic       acc_ack_out,
	input wire logic       ew_mode_out,
	input wire logic       flash_ready_flag_out,
	input wire logic [7:0] operation_result_register_out,
	input wire logic       arr_we_out,
	input wire logic       arr_erase_out,
	input wire logic       lock_clr_out
);
	localparam int MAXW = 1000;
	// Any of the three error flags
	wire err = |operation_result_register_out[5:3];
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	a_read_ack: assert property (acc_req_in && !acc_we_in |-> ##2 acc_ack_out)
		else $error("read not answered after two cycles");
	a_write_ack: assert property (acc_req_in && acc_we_in |=> acc_ack_out)
		else $error("write not answered after one cycle");
	a_ack_cause: assert property ($rose(acc_ack_out)
		|-> $past(acc_req_in) || $past(acc_req_in, 2))
		else $error("answer without a request");
	a_mode_entry: assert property (ew_mode_out
		|-> $past(ew_mode_entry_bit_in) && $past(flash_program_pin_in, 3))
		else $error("command mode without pin and entry bit");
	a_idle_writes: assert property (!ew_mode_out [*3]
		|-> !arr_we_out && !arr_erase_out && !lock_clr_out)
		else $error("array changed outside command mode");
	a_erase_busy: assert property (arr_erase_out |=> !flash_ready_flag_out)
		else $error("ready high during erase");
	a_prog_busy: assert property (arr_we_out |=> !flash_ready_flag_out)
		else $error("ready high during program");
	a_err_block: assert property (err && flash_ready_flag_out
		|=> !arr_erase_out && !lock_clr_out)
		else $error("operation started with error flag set");
	a_ready_back: assert property ($fell(flash_ready_flag_out)
		|-> ##[1:MAXW] flash_ready_flag_out)
		else $error("ready never returned");
	c_erase: cover property (arr_erase_out);
	c_lock: cover property (lock_clr_out);
	c_prog: cover property (arr_we_out);
endmodule
`default_nettype wire

//--- testbench/fcs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model (
	input  wire logic        clk_in,
	input  wire logic [18:0] addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        we_in,
	input  wire logic        erase_in,
	input  wire logic [3:0]  eblk_in,
	input  wire logic        clr_in,
	input  wire logic        set_in,
	input  wire logic [3:0]  lblk_in,
	output wire logic [15:0] rdata_out,
	output var  logic [10:0] lock_out
);
	logic [15:0] mem_q [0:127];
	// Lock bits have no reset input, so they outlive device resets
	initial begin
		lock_out = 11'h7ff;
		for (int i = 0; i < 128; i++)
			mem_q[i] = 16'hffff;
	end
	// Only page zero is stored; every other place reads as erased
	assign rdata_out = (addr_in[18:8] == 11'h0) ? mem_q[addr_in[7:1]]
		: 16'hffff;
	// Program, erase and lock-bit updates
	always @(posedge clk_in) begin
		if (we_in && addr_in[18:8] == 11'h0)
			mem_q[addr_in[7:1]] <= wdata_in;
		if (erase_in && eblk_in == 4'h0)
			for (int i = 0; i < 128; i++)
				mem_q[i] <= 16'hffff;
		if (clr_in)
			lock_out[lblk_in] <= 1'b0;
		if (set_in)
			lock_out[lblk_in] <= 1'b1;
	end
endmodule
`default_nettype wire

//--- testbench/fcs_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fcs_sequencer_tb;
	logic        clk_in = 0;
	logic        rst_in = 1;
	logic        pin    = 0;
	logic        entry  = 1;
	logic        ovr    = 0;
	logic        req    = 0;
	logic        we     = 0;
	logic [18:0] addr   = 0;
	logic [15:0] wdata  = 0;
	logic [15:0] rdata, rv, ard, awd;
	logic        ack, mode, rdy, awe, aer, lclr, lset;
	logic [7:0]  res;
	logic [18:0] aad;
	logic [3:0]  ablk, lblk;
	logic [10:0] lbits;
	int          fail_count = 0;
	int          tests_run  = 0;
	int          cyc        = 0;
	fcs_sequencer #(.PROG_CYC(20'd20), .ERASE_CYC(20'd30)) fcs_sequencer_i (
		.clk_in(clk_in), .rst_in(rst_in), .flash_program_pin_in(pin),
		.ew_mode_entry_bit_in(entry), .lock_override_bit_in(ovr),
		.acc_req_in(req), .acc_we_in(we), .acc_addr_in(addr),
		.acc_wdata_in(wdata), .acc_rdata_out(rdata), .acc_ack_out(ack),
		.ew_mode_out(mode), .flash_ready_flag_out(rdy),
		.operation_result_register_out(res), .arr_addr_out(aad),
		.arr_wdata_out(awd), .arr_we_out(awe), .arr_erase_out(aer),
		.arr_erase_blk_out(ablk), .arr_rdata_in(ard), .lock_bits_in(lbits),
		.lock_clr_out(lclr), .lock_set_out(lset), .lock_blk_out(lblk));
	fcs_flash_model fcs_flash_model_i (
		.clk_in(clk_in), .addr_in(aad), .wdata_in(awd), .we_in(awe),
		.erase_in(aer), .eblk_in(ablk), .clr_in(lclr), .set_in(lset),
		.lblk_in(lblk), .rdata_out(ard), .lock_out(lbits));
	// Free-running clock, 50 ns period
	initial forever #25 clk_in = ~clk_in;
	// Cuts a hang short
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			stop_test;
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic chkb(input logic seen, input logic exp);
		check({15'h0, seen}, {15'h0, exp});
	endtask
	// One strobed access, then wait for its answer
	task automatic acc(input logic w, input logic [18:0] a,
		input logic [15:0] d);
		@(negedge clk_in);
		req = 1;
		we = w;
		addr = a;
		wdata = d;
		@(negedge clk_in);
		req = 0;
		for (int i = 0; i < 4 && ack !== 1'b1; i++)
			@(negedge clk_in);
		chkb(ack, 1'b1);
		rv = rdata;
	endtask
	task automatic rd_status(input logic [15:0] exp);
		acc(1, 0, 16'h7070);
		acc(0, 0, 0);
		check(rv, exp);
	endtask
	task automatic wait_rdy;
		repeat (2) @(negedge clk_in);
		for (int i = 0; i < 1000 && rdy !== 1'b1; i++)
			@(negedge clk_in);
		chkb(rdy, 1'b1);
	endtask
	task automatic prog(input logic [18:0] base);
		acc(1, 0, 16'h4141);
		for (int i = 0; i < 128; i++)
			acc(1, base + 19'(2 * i), 16'h5a00 + 16'(i));
		repeat (3) @(negedge clk_in);
	endtask
	task automatic t_mode;
		acc(1, 0, 16'h2020);
		acc(1, 19'h03ffe, 16'hd0d0);
		repeat (3) @(negedge clk_in);
		chkb(rdy, 1'b1);
		chkb(mode, 1'b0);
		pin = 1;
		repeat (5) @(negedge clk_in);
		chkb(mode, 1'b1);
		$display("mode test done");
	endtask
	task automatic t_page;
		prog(19'h0);
		chkb(rdy, 1'b0);
		// While busy an erase is refused and reads give the result word
		acc(1, 0, 16'h2020);
		acc(1, 19'h03ffe, 16'hd0d0);
		rd_status(16'h0000);
		wait_rdy;
		rd_status(16'h0080);
		acc(1, 0, 16'hffff);
		acc(0, 19'h000fe, 0);
		check(rv, 16'h5a7f);
		acc(0, 19'h00002, 0);
		check(rv, 16'h5a01);
		$display("page test done");
	endtask
	task automatic t_lock;
		acc(1, 0, 16'h7777);
		acc(1, 19'h05ffe, 16'hd0d0);
		wait_rdy;
		check({5'h0, lbits}, 16'h07fd);
		@(negedge clk_in);
		rst_in = 1;
		repeat (2) @(negedge clk_in);
		rst_in = 0;
		repeat (5) @(negedge clk_in);
		acc(1, 0, 16'h7171);
		acc(0, 19'h05ffe, 0);
		check(rv, 16'h0000);
		acc(0, 19'h03ffe, 0);
		check(rv, 16'h0202);
		acc(0, 19'h7fffe, 0);
		check(rv, 16'h0202);
		$display("lock test done");
	endtask
	task automatic t_errs;
		acc(1, 0, 16'h2020);
		acc(1, 19'h05ffe, 16'hd0d0);
		repeat (3) @(negedge clk_in);
		rd_status(16'h00a0);
		acc(1, 0, 16'h2020);
		acc(1, 19'h03ffe, 16'hd0d0);
		repeat (3) @(negedge clk_in);
		chkb(rdy, 1'b1);
		acc(1, 0, 16'h5050);
		rd_status(16'h0080);
		prog(19'h04000);
		wait_rdy;
		rd_status(16'h0090);
		acc(1, 0, 16'h5050);
		acc(1, 0, 16'h2020);
		acc(1, 0, 16'hffff);
		rd_status(16'h0080);
		acc(1, 0, 16'h7777);
		acc(1, 19'h03ffe, 16'h4141);
		rd_status(16'h0090);
		check({5'h0, lbits}, 16'h07fd);
		acc(1, 0, 16'h5050);
		$display("error test done");
	endtask
	task automatic t_erase;
		acc(1, 0, 16'h2020);
		acc(1, 19'h03ffe, 16'hd0d0);
		wait_rdy;
		acc(1, 0, 16'hffff);
		acc(0, 19'h000fe, 0);
		check(rv, 16'hffff);
		prog(19'h0);
		wait_rdy;
		acc(1, 0, 16'ha7a7);
		acc(1, 19'h12344, 16'hd0d0);
		wait_rdy;
		acc(1, 0, 16'hffff);
		acc(0, 19'h000fe, 0);
		check(rv, 16'hffff);
		check({5'h0, lbits}, 16'h07fd);
		ovr = 1;
		// Block erase under override unprotects the block
		acc(1, 0, 16'h2020);
		acc(1, 19'h05ffe, 16'hd0d0);
		wait_rdy;
		check({5'h0, lbits}, 16'h07ff);
		acc(1, 0, 16'h7777);
		acc(1, 19'h07ffe, 16'hd0d0);
		wait_rdy;
		check({5'h0, lbits}, 16'h07fb);
		acc(1, 0, 16'ha7a7);
		acc(1, 0, 16'hd0d0);
		wait_rdy;
		check({5'h0, lbits}, 16'h07ff);
		// Back to array read, then leave command mode
		acc(1, 0, 16'hffff);
		pin = 0;
		repeat (5) @(negedge clk_in);
		chkb(mode, 1'b0);
		$display("erase test done");
	endtask
	task automatic stop_test;
		$display("compares=%0d mismatches=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (16) @(negedge clk_in);
		check({8'h0, res}, 16'h0080);
		rst_in = 0;
		repeat (4) @(negedge clk_in);
		chkb(rdy, 1'b1);
		t_mode;
		t_page;
		t_lock;
		t_errs;
		t_erase;
		stop_test;
	end
endmodule
bind fcs_sequencer fcs_chk #(.PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC))
	fcs_chk_i (.clk_in, .rst_in, .flash_program_pin_in,
	.ew_mode_entry_bit_in, .acc_req_in, .acc_we_in, .acc_ack_out,
	.ew_mode_out, .flash_ready_flag_out, .operation_result_register_out,
	.arr_we_out, .arr_erase_out, .lock_clr_out);
`default_nettype wire
